// ==== dscc_pkg.sv ====
// Purpose: shared constants for the converter serial configuration link
// Assumes: 200 MHz system clock, 5-bit register space of 8-bit registers
// Notes: host command registers sit at word offsets on the plain port
package dscc_pkg;
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int SCLK_MAX_KHZ = 15000;
  localparam int SCLK_HALF = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int SETTLE_MCLK = 200;
  localparam int SETTLE_CYC = SETTLE_MCLK;
  // Device register addresses
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_PLL = 5'h02;
  localparam logic [4:0] A_I_FINE = 5'h05;
  localparam logic [4:0] A_I_COARSE = 5'h06;
  localparam logic [4:0] A_I_OFS_LO = 5'h07;
  localparam logic [4:0] A_I_OFS_HI = 5'h08;
  localparam logic [4:0] A_Q_FINE = 5'h09;
  localparam logic [4:0] A_Q_COARSE = 5'h0A;
  localparam logic [4:0] A_Q_OFS_LO = 5'h0B;
  localparam logic [4:0] A_Q_OFS_HI = 5'h0C;
  localparam logic [4:0] A_REF = 5'h0D;
  // Device register fields
  localparam int B_BIDIR = 7;
  localparam int B_LSB = 6;
  localparam int B_SRST = 5;
  localparam int B_OFS_DIR = 7;
  localparam int B_REF_SHARED = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COARSE_RESET = 8'h0F;
  // Instruction byte fields
  localparam int I_RW = 7;
  localparam int I_CNT = 5;
  localparam int I_ADDR = 0;
  // Host command registers (byte addresses)
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_WDATA = 4'h4;
  localparam logic [3:0] H_RDATA = 4'h8;
  localparam logic [3:0] H_STAT = 4'hC;
  localparam int HC_START = 0;
  localparam int HC_RW = 1;
  localparam int HC_CNT = 2;
  localparam int HC_ADDR = 4;
  localparam int HC_LSB = 9;
  localparam int HC_BIDIR = 10;
  localparam int HS_BUSY = 0;
  localparam int HS_DONE = 1;
  // Source array segmentation
  localparam int CODE_W = 12;
  localparam int MAJ_N = 31;
  localparam int MID_N = 15;
  localparam int LSB_N = 3;
  localparam int SW_N = MAJ_N + MID_N + LSB_N;
endpackage

// ==== dscc_if.sv ====
// Purpose: serial link between host controller and converter config port
// Assumes: two-way data pin resolved here from output enables
// Notes: undriven lines read high, as with a pull-up
`timescale 1ns/1ps
`default_nettype none
interface dscc_if;
  logic sclk;
  logic csb_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic dev_sdo_o;
  logic dev_sdo_oe_n;
  logic sdio;
  logic sdo;

  assign sdio = !host_sdio_oe_n ? host_sdio_o : (!dev_sdio_oe_n ? dev_sdio_o : 1'b1);
  assign sdo = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;

  modport host (output sclk, output csb_n, output host_sdio_o, output host_sdio_oe_n,
                input sdio, input sdo);
  modport device (input sclk, input csb_n, output dev_sdio_o, output dev_sdio_oe_n,
                  output dev_sdo_o, output dev_sdo_oe_n, input sdio);
endinterface
`default_nettype wire

// ==== dscc_seg_decoder.sv ====
// Purpose: 5-4-3 segmented decode of an input code into source switches
// Assumes: a set switch routes its source to the true output
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module dscc_seg_decoder (
  // Code in
  input wire logic [dscc_pkg::CODE_W-1:0] code,
  // Switches out
  output logic [dscc_pkg::SW_N-1:0] sw
);
  genvar g;
  // Thermometer decode keeps the major and middle sources equal-weight
  for (g = 0; g < dscc_pkg::MAJ_N; g++) begin : g_maj
    assign sw[g] = code[11:7] > 5'(g);
  end
  for (g = 0; g < dscc_pkg::MID_N; g++) begin : g_mid
    assign sw[dscc_pkg::MAJ_N+g] = code[6:3] > 4'(g);
  end
  assign sw[dscc_pkg::SW_N-1 -: dscc_pkg::LSB_N] = code[2:0];
endmodule // dscc_seg_decoder
`default_nettype wire

// ==== dscc_device.sv ====
// Purpose: converter end of the serial configuration link and its register bank
// Assumes: link pins sampled on clk; one clk cycle stands for one master clock
// Notes: new settings reach the converter path together at end of transfer, or at once on a soft reset
`timescale 1ns/1ps
`default_nettype none
module dscc_device (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link
  dscc_if.device link,
  // Converter codes
  input wire logic [dscc_pkg::CODE_W-1:0] i_code,
  input wire logic [dscc_pkg::CODE_W-1:0] q_code,
  // Source switches, 1 = true output
  output logic [dscc_pkg::SW_N-1:0] i_sw_q,
  output logic [dscc_pkg::SW_N-1:0] q_sw_q,
  // Offset currents per output side
  output logic [9:0] i_ofs_true_q,
  output logic [9:0] i_ofs_comp_q,
  output logic [9:0] q_ofs_true_q,
  output logic [9:0] q_ofs_comp_q,
  // Reference levels after gain
  output logic [7:0] i_ref_level_q,
  output logic [7:0] q_ref_level_q,
  output logic shared_reference_mode_q,
  // Multiplier setting and settle status
  output logic [7:0] input_multiplier_setting_q,
  output logic clock_stable_q
);
  localparam logic [7:0] SETTLE_MAX = 8'(dscc_pkg::SETTLE_CYC);

  function automatic logic [7:0] reg_default(input logic [4:0] a);
    reg_default = (a == dscc_pkg::A_I_COARSE || a == dscc_pkg::A_Q_COARSE) ?
                  dscc_pkg::COARSE_RESET : dscc_pkg::REG_RESET;
  endfunction

  function automatic logic [7:0] ref_level(input logic [7:0] coarse, input logic [7:0] fine,
                                           input logic shared);
    logic [7:0] base;
    base = {coarse[3:0], 4'h0};
    if (shared) begin
      base = {1'b0, base[7:1]};
    end
    ref_level = (base > {2'b00, fine[5:0]}) ? base - {2'b00, fine[5:0]} : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  logic [2:0] sclk_s_q;
  logic [1:0] csb_s_q;
  logic [1:0] sdio_s_q;
  logic csb_d1_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic cs_end;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_s_q <= 3'h0;
      csb_s_q <= 2'h3;
      sdio_s_q <= 2'h3;
      csb_d1_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], link.sclk};
      csb_s_q <= {csb_s_q[0], link.csb_n};
      sdio_s_q <= {sdio_s_q[0], link.sdio};
      csb_d1_q <= csb_s_q[1];
    end
  end

  assign cs_active = !csb_s_q[1];
  assign sclk_rise = cs_active && sclk_s_q[1] && !sclk_s_q[2];
  assign sclk_fall = cs_active && !sclk_s_q[1] && sclk_s_q[2];
  assign cs_end = csb_s_q[1] && !csb_d1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift and transfer state
  logic [7:0] regs_q [32];
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] byte_full;
  logic [2:0] bit_idx;
  logic lsb_first;
  logic bidir;
  logic instr_q;
  logic rw_q;
  logic over_q;
  logic [1:0] left_q;
  logic [4:0] addr_q;
  logic wr_en;

  assign lsb_first = regs_q[dscc_pkg::A_CTRL][dscc_pkg::B_LSB];
  assign bidir = regs_q[dscc_pkg::A_CTRL][dscc_pkg::B_BIDIR];
  assign bit_idx = lsb_first ? bit_cnt_q : 3'd7 - bit_cnt_q;

  always_comb begin
    byte_full = shift_q;
    byte_full[bit_idx] = sdio_s_q[1];
  end

  assign wr_en = sclk_rise && bit_cnt_q == 3'd7 && instr_q && !over_q && !rw_q;

  // Raising chip select abandons any partial byte
  always_ff @(posedge clk) begin
    if (reset || !cs_active) begin
      bit_cnt_q <= 3'd0;
      shift_q <= 8'h00;
      instr_q <= 1'b0;
      rw_q <= 1'b0;
      over_q <= 1'b0;
      left_q <= 2'd0;
      addr_q <= 5'h00;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      shift_q <= (bit_cnt_q == 3'd7) ? 8'h00 : byte_full;
      if (bit_cnt_q == 3'd7) begin
        if (!instr_q) begin
          instr_q <= 1'b1;
          rw_q <= byte_full[dscc_pkg::I_RW];
          left_q <= byte_full[dscc_pkg::I_CNT +: 2];
          addr_q <= byte_full[dscc_pkg::I_ADDR +: 5];
        end else if (!over_q) begin
          addr_q <= lsb_first ? addr_q + 5'h01 : addr_q - 5'h01;
          over_q <= left_q == 2'd0;
          left_q <= left_q - 2'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank, soft reset and recovery
  logic srst_pulse;
  logic mirrored;
  logic recover_q;
  logic reprog;
  logic [7:0] settle_q;

  assign srst_pulse = wr_en && addr_q == dscc_pkg::A_CTRL && byte_full[dscc_pkg::B_SRST];
  // A byte equal to its own reversal lands the same in either bit order
  assign mirrored = byte_full == {<<{byte_full}};
  assign reprog = wr_en && addr_q == dscc_pkg::A_CTRL && !byte_full[dscc_pkg::B_SRST] && recover_q;

  always_ff @(posedge clk) begin
    for (int a = 0; a < 32; a++) begin
      if (reset) begin
        regs_q[a] <= reg_default(5'(a));
      end else if (srst_pulse && a != 0) begin
        regs_q[a] <= reg_default(5'(a));
      end else if (wr_en && addr_q == 5'(a)) begin
        regs_q[a] <= byte_full;
        if (a == 0) begin
          regs_q[a][dscc_pkg::B_SRST] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      recover_q <= 1'b0;
    end else if (srst_pulse) begin
      recover_q <= mirrored;
    end else if (reprog) begin
      recover_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      input_multiplier_setting_q <= 8'h00;
      settle_q <= 8'h00;
      clock_stable_q <= 1'b1;
    end else if (reprog) begin
      input_multiplier_setting_q <= regs_q[dscc_pkg::A_PLL];
      settle_q <= SETTLE_MAX - 8'h01;
      clock_stable_q <= 1'b0;
    end else if (settle_q != 8'h00) begin
      settle_q <= settle_q - 8'h01;
    end else begin
      clock_stable_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back drive, changed on the falling serial edge
  logic drive_rd;
  logic rd_bit_q;
  logic sdio_oe_n_q;
  logic sdo_oe_n_q;

  assign drive_rd = cs_active && instr_q && rw_q && !over_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_bit_q <= 1'b0;
      sdio_oe_n_q <= 1'b1;
      sdo_oe_n_q <= 1'b1;
    end else begin
      if (sclk_fall && drive_rd) begin
        rd_bit_q <= regs_q[addr_q][bit_idx];
      end
      // Taking the pin only on a falling edge leaves the host time to let go
      if (!drive_rd) begin
        sdio_oe_n_q <= 1'b1;
        sdo_oe_n_q <= 1'b1;
      end else if (sclk_fall) begin
        sdio_oe_n_q <= !bidir;
        sdo_oe_n_q <= bidir;
      end
    end
  end

  assign link.dev_sdio_o = rd_bit_q;
  assign link.dev_sdo_o = rd_bit_q;
  assign link.dev_sdio_oe_n = sdio_oe_n_q;
  assign link.dev_sdo_oe_n = sdo_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converter path: settings applied together, codes decoded each cycle
  logic apply_q;
  logic [dscc_pkg::SW_N-1:0] i_sw_d;
  logic [dscc_pkg::SW_N-1:0] q_sw_d;
  logic [9:0] i_mag;
  logic [9:0] q_mag;

  // Applying at transfer end keeps multi-byte values from tearing
  always_ff @(posedge clk) begin
    if (reset) begin
      apply_q <= 1'b1;
    end else begin
      apply_q <= cs_end || srst_pulse;
    end
  end

  assign i_mag = {regs_q[dscc_pkg::A_I_OFS_HI][1:0], regs_q[dscc_pkg::A_I_OFS_LO]};
  assign q_mag = {regs_q[dscc_pkg::A_Q_OFS_HI][1:0], regs_q[dscc_pkg::A_Q_OFS_LO]};

  always_ff @(posedge clk) begin
    if (reset) begin
      i_ofs_true_q <= 10'h000;
      i_ofs_comp_q <= 10'h000;
      q_ofs_true_q <= 10'h000;
      q_ofs_comp_q <= 10'h000;
      i_ref_level_q <= 8'h00;
      q_ref_level_q <= 8'h00;
      shared_reference_mode_q <= 1'b0;
    end else if (apply_q) begin
      // Exactly one side carries the offset
      i_ofs_true_q <= regs_q[dscc_pkg::A_I_OFS_HI][dscc_pkg::B_OFS_DIR] ? i_mag : 10'h000;
      i_ofs_comp_q <= regs_q[dscc_pkg::A_I_OFS_HI][dscc_pkg::B_OFS_DIR] ? 10'h000 : i_mag;
      q_ofs_true_q <= regs_q[dscc_pkg::A_Q_OFS_HI][dscc_pkg::B_OFS_DIR] ? q_mag : 10'h000;
      q_ofs_comp_q <= regs_q[dscc_pkg::A_Q_OFS_HI][dscc_pkg::B_OFS_DIR] ? 10'h000 : q_mag;
      shared_reference_mode_q <= regs_q[dscc_pkg::A_REF][dscc_pkg::B_REF_SHARED];
      i_ref_level_q <= ref_level(regs_q[dscc_pkg::A_I_COARSE], regs_q[dscc_pkg::A_I_FINE],
                                 regs_q[dscc_pkg::A_REF][dscc_pkg::B_REF_SHARED]);
      q_ref_level_q <= ref_level(regs_q[dscc_pkg::A_Q_COARSE], regs_q[dscc_pkg::A_Q_FINE],
                                 regs_q[dscc_pkg::A_REF][dscc_pkg::B_REF_SHARED]);
    end
  end

  dscc_seg_decoder u_i_dec (
    .code (i_code),
    .sw (i_sw_d)
  );

  dscc_seg_decoder u_q_dec (
    .code (q_code),
    .sw (q_sw_d)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      i_sw_q <= '0;
      q_sw_q <= '0;
    end else begin
      i_sw_q <= i_sw_d;
      q_sw_q <= q_sw_d;
    end
  end
endmodule // dscc_device
`default_nettype wire

// ==== dscc_host.sv ====
// Purpose: host end; runs serial transfers ordered through its own registers
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: follows its own writes to 00h so later bytes use the new format
`timescale 1ns/1ps
`default_nettype none
module dscc_host #(
  parameter int HALF = dscc_pkg::SCLK_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  // Serial link
  dscc_if.host link
);
  typedef enum {ST_IDLE, ST_RUN, ST_END} dscc_hstate_t;

  dscc_hstate_t state_q;
  logic rw_q;
  logic [1:0] cnt_q;
  logic [4:0] addr_q;
  logic lsb_q;
  logic bidir_q;
  logic [31:0] wdata_q;
  logic [31:0] rx_q;
  logic done_q;
  logic start;
  logic [7:0] div_q;
  logic tick;
  logic sclk_q;
  logic csb_q;
  logic sdo_q;
  logic oe_n_q;
  logic [5:0] bit_q;
  logic lsb_live_q;
  logic bidir_live_q;
  logic [4:0] cur_addr_q;
  logic [1:0] in_s_q;
  logic [2:0] pos_idx;
  logic [7:0] cur_byte;
  logic [5:0] last_bit;
  logic in_read_data;

  ////////////////////////////////////////////////////////////////////////////
  // Command registers
  assign start = wr && addr == dscc_pkg::H_CTRL && wdata[dscc_pkg::HC_START] && state_q == ST_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      rw_q <= 1'b0;
      cnt_q <= 2'd0;
      addr_q <= 5'h00;
      lsb_q <= 1'b0;
      bidir_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
    end else if (wr && state_q == ST_IDLE) begin
      if (addr == dscc_pkg::H_CTRL) begin
        rw_q <= wdata[dscc_pkg::HC_RW];
        cnt_q <= wdata[dscc_pkg::HC_CNT +: 2];
        addr_q <= wdata[dscc_pkg::HC_ADDR +: 5];
        lsb_q <= wdata[dscc_pkg::HC_LSB];
        bidir_q <= wdata[dscc_pkg::HC_BIDIR];
      end else if (addr == dscc_pkg::H_WDATA) begin
        wdata_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        dscc_pkg::H_CTRL: rdata_q <= {21'h0, bidir_q, lsb_q, addr_q, cnt_q, rw_q, 1'b0};
        dscc_pkg::H_WDATA: rdata_q <= wdata_q;
        dscc_pkg::H_RDATA: rdata_q <= rx_q;
        dscc_pkg::H_STAT: rdata_q <= {30'h0, done_q, state_q != ST_IDLE};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Completion wins over a clearing status read in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (state_q == ST_END && tick) begin
      done_q <= 1'b1;
    end else if (rd && addr == dscc_pkg::H_STAT) begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock divider and bit sequencing
  assign tick = div_q == 8'(HALF - 1);
  assign last_bit = {1'b0, cnt_q, 3'd7} + 6'd8;
  assign pos_idx = lsb_live_q ? bit_q[2:0] : 3'd7 - bit_q[2:0];
  assign cur_byte = (bit_q[5:3] == 3'd0) ? {rw_q, cnt_q, addr_q} : wdata_q[8 * (bit_q[5:3] - 3'd1) +: 8];
  assign in_read_data = rw_q && bit_q[5:3] != 3'd0;

  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      in_s_q <= 2'h3;
    end else begin
      in_s_q <= {in_s_q[0], bidir_live_q ? link.sdio : link.sdo};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      sclk_q <= 1'b0;
      csb_q <= 1'b1;
      bit_q <= 6'd0;
      lsb_live_q <= 1'b0;
      bidir_live_q <= 1'b0;
      cur_addr_q <= 5'h00;
      rx_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_RUN;
            csb_q <= 1'b0;
            bit_q <= 6'd0;
            lsb_live_q <= wdata[dscc_pkg::HC_LSB];
            bidir_live_q <= wdata[dscc_pkg::HC_BIDIR];
            cur_addr_q <= wdata[dscc_pkg::HC_ADDR +: 5];
            rx_q <= 32'h0000_0000;
          end
        end
        ST_RUN: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            if (in_read_data) begin
              rx_q[{bit_q[4:3] - 2'd1, pos_idx}] <= in_s_q[1];
            end
          end else if (tick) begin
            sclk_q <= 1'b0;
            if (bit_q[2:0] == 3'd7 && bit_q[5:3] != 3'd0) begin
              cur_addr_q <= lsb_live_q ? cur_addr_q + 5'h01 : cur_addr_q - 5'h01;
              // Our own write to 00h retimes every later byte
              if (!rw_q && cur_addr_q == dscc_pkg::A_CTRL) begin
                lsb_live_q <= cur_byte[dscc_pkg::B_LSB];
                bidir_live_q <= cur_byte[dscc_pkg::B_BIDIR];
              end
            end
            if (bit_q == last_bit) begin
              state_q <= ST_END;
            end else begin
              bit_q <= bit_q + 6'd1;
            end
          end
        end
        ST_END: begin
          if (tick) begin
            csb_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Data is presented while the serial clock is low
  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      sdo_q <= cur_byte[pos_idx];
      oe_n_q <= state_q == ST_IDLE || in_read_data;
    end
  end

  assign link.sclk = sclk_q;
  assign link.csb_n = csb_q;
  assign link.host_sdio_o = sdo_q;
  assign link.host_sdio_oe_n = oe_n_q;
endmodule // dscc_host
`default_nettype wire

// ==== dscc_checker.sv ====
// Purpose: wire-level checks on the serial configuration link
// Assumes: HALF clk cycles per serial half period
// Notes: watches interface signals only
`timescale 1ns/1ps
`default_nettype none
module dscc_checker #(
  parameter int HALF = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_oe_n,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe_n
);
  int hi_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset || !sclk) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end
  ////////////////////////////////////////////////////////////
  sclk_half_a: assert property ($fell(sclk) |-> hi_cnt == HALF)
    else $error("serial clock high time wrong");
  sclk_idle_a: assert property (csb_n && $past(csb_n) |-> !sclk)
    else $error("serial clock moves outside a frame");
  csb_end_a: assert property ($rose(csb_n) |-> !$past(sclk))
    else $error("frame ends with serial clock high");
  host_hold_a: assert property (sclk && $past(sclk) |-> $stable(host_sdio_o))
    else $error("host data changes while serial clock high");
  dev_hold_a: assert property (!dev_sdo_oe_n && sclk && $past(sclk) |-> $stable(dev_sdo_o))
    else $error("device data changes while serial clock high");
  one_driver_a: assert property (host_sdio_oe_n || dev_sdio_oe_n)
    else $error("two drivers on the data pin");
  one_out_a: assert property (dev_sdio_oe_n || dev_sdo_oe_n)
    else $error("device drives both data pins");
  idle_release_a: assert property (csb_n [*8] |-> dev_sdio_oe_n && dev_sdo_oe_n)
    else $error("device drives while deselected");
  cover property ($fell(csb_n));
  cover property (!dev_sdo_oe_n);
  cover property ($rose(sclk) && !host_sdio_oe_n);
endmodule // dscc_checker
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for host and device ends joined by the link
// Assumes: host HALF at its default
// Notes: reads queue their expectations; a monitor pops and compares
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LIMIT = 40000;
  logic clk, reset, wr, rd, chk, chk_d, shared, stable;
  logic [3:0] addr;
  logic [31:0] wdata, rdata_q;
  logic [11:0] i_code, q_code;
  logic [dscc_pkg::SW_N-1:0] i_sw, q_sw;
  logic [9:0] i_ot, i_oc, q_ot, q_oc;
  logic [7:0] i_ref, q_ref, mult;
  logic [63:0] exp_q[$], msk_q[$];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  dscc_if link ();
  dscc_host dscc_host_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .link(link));
  dscc_device dscc_device_i (.clk(clk), .reset(reset), .link(link), .i_code(i_code), .q_code(q_code),
    .i_sw_q(i_sw), .q_sw_q(q_sw), .i_ofs_true_q(i_ot), .i_ofs_comp_q(i_oc), .q_ofs_true_q(q_ot),
    .q_ofs_comp_q(q_oc), .i_ref_level_q(i_ref), .q_ref_level_q(q_ref), .shared_reference_mode_q(shared),
    .input_multiplier_setting_q(mult), .clock_stable_q(stable));
  dscc_checker #(.HALF(dscc_pkg::SCLK_HALF)) dscc_checker_i (.clk(clk), .reset(reset), .sclk(link.sclk),
    .csb_n(link.csb_n), .host_sdio_o(link.host_sdio_o), .host_sdio_oe_n(link.host_sdio_oe_n),
    .dev_sdio_oe_n(link.dev_sdio_oe_n), .dev_sdo_o(link.dev_sdo_o), .dev_sdo_oe_n(link.dev_sdo_oe_n));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    chk <= c;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    chk <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic rw, input int n, input logic [4:0] a, input logic lsb);
    return 32'(rw) << dscc_pkg::HC_RW | 32'(n - 1) << dscc_pkg::HC_CNT | 32'(a) << dscc_pkg::HC_ADDR
      | 32'(lsb) << dscc_pkg::HC_LSB | 32'h0000_0001;
  endfunction
  // Polls status; settings apply a few cycles after the frame (chip select synchroniser, then apply), so wait a few more
  task automatic xfer(input logic [31:0] c, input logic [31:0] d);
    bus(1'b1, dscc_pkg::H_WDATA, d, 1'b0);
    bus(1'b1, dscc_pkg::H_CTRL, c, 1'b0);
    repeat (600) begin
      bus(1'b0, dscc_pkg::H_STAT, 32'h0, 1'b0);
      #1;
      if (rdata_q[dscc_pkg::HS_DONE] === 1'b1) begin
        repeat (3) @(posedge clk);
        #1;
        return;
      end
    end
    check("transfer done", 0, 1);
  endtask
  task automatic qrd(input logic [3:0] a, input logic [63:0] e, input logic [63:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic rd_dev(input logic [4:0] a, input logic lsb, input logic [7:0] e);
    xfer(ctl(1'b1, 1, a, lsb), 32'h0);
    qrd(dscc_pkg::H_RDATA, 64'(e), 64'h0000_0000_0000_00FF);
  endtask
  function automatic logic [dscc_pkg::SW_N-1:0] sw_exp(input logic [11:0] c);
    logic [dscc_pkg::SW_N-1:0] s;
    s = '0;
    for (int k = 0; k < dscc_pkg::MAJ_N; k++) s[k] = (k < c[11:7]);
    for (int k = 0; k < dscc_pkg::MID_N; k++) s[31 + k] = (k < c[6:3]);
    s[48:46] = c[2:0];
    return s;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    chk_d <= chk;
    cyc <= cyc + 1;
    if (chk_d === 1'b1) check("read data", rdata_q & msk_q.pop_front(), exp_q.pop_front());
    if (cyc > LIMIT) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    chk = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    i_code = 12'h000;
    q_code = 12'h000;
    void'($urandom(13818));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("i ref", i_ref, 8'hF0);
    check("stable", stable, 1);
    $display("test defaults done");
    xfer(ctl(1'b0, 2, 5'h08, 1'b0), 32'h0000_2381);
    check("i ofs true", i_ot, 10'h123);
    check("i ofs comp", i_oc, 0);
    rd_dev(5'h08, 1'b0, 8'h81);
    qrd(4'h2, 0, 64'h0000_0000_FFFF_FFFF);
    $display("test offsets done");
    // Format change in a single byte, then later transfers in the new order
    xfer(ctl(1'b0, 1, 5'h00, 1'b0), 32'h40);
    xfer(ctl(1'b0, 2, 5'h0B, 1'b1), 32'h0000_0245);
    check("q ofs comp", q_oc, 10'h245);
    check("q ofs true", q_ot, 0);
    rd_dev(5'h00, 1'b1, 8'h40);
    // 00h rewritten in the first byte; the second byte goes out in the new order
    xfer(ctl(1'b0, 2, 5'h00, 1'b1), 32'h0000_3700);
    rd_dev(5'h01, 1'b0, 8'h37);
    xfer(ctl(1'b0, 1, 5'h00, 1'b0), 32'h0000_0080);
    xfer(ctl(1'b1, 1, 5'h00, 1'b0) | 32'h0000_0400, 32'h0);
    qrd(dscc_pkg::H_RDATA, 64'h0000_0000_0000_0080, 64'h0000_0000_0000_00FF);
    xfer(ctl(1'b0, 1, 5'h00, 1'b0), 32'h0000_0040);
    $display("test bit order done");
    xfer(ctl(1'b0, 1, 5'h0D, 1'b1), 32'h01);
    xfer(ctl(1'b0, 2, 5'h05, 1'b1), 32'h0000_0A10);
    check("i ref", i_ref, 8'h40);
    check("q ref", q_ref, 8'h78);
    check("shared", shared, 1);
    $display("test gain done");
    xfer(ctl(1'b0, 1, 5'h00, 1'b1), 32'h60);
    check("i ofs true", i_ot, 0);
    check("q ofs comp", q_oc, 0);
    check("q ref", q_ref, 8'hF0);
    rd_dev(5'h00, 1'b1, 8'h40);
    $display("test soft reset done");
    xfer(ctl(1'b0, 1, 5'h08, 1'b1), 32'h81);
    xfer(ctl(1'b0, 1, 5'h00, 1'b1), 32'h66);
    check("i ofs true", i_ot, 0);
    xfer(ctl(1'b0, 1, 5'h02, 1'b1), 32'h5A);
    xfer(ctl(1'b0, 1, 5'h00, 1'b1), 32'h40);
    check("stable low", stable, 0);
    check("multiplier", mult, 8'h5A);
    repeat (dscc_pkg::SETTLE_CYC) @(posedge clk);
    check("stable high", stable, 1);
    $display("test recovery done");
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      i_code <= (n == 0) ? 12'hFFF : 12'($urandom);
      q_code <= (n == 0) ? 12'h000 : 12'($urandom);
      repeat (2) @(posedge clk);
      #1;
      check("i switches", i_sw, sw_exp(i_code));
      check("q switches", q_sw, sw_exp(q_code));
    end
    $display("test decode done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
